// *** logic/ddic_pkg.sv ***
package ddic_pkg;
  // Unit number width; the cable carries one select code per drive
  localparam int UNIT_W          = 2;
  // Holding register field positions
  localparam int HOLD_W          = 5;
  localparam int HOLD_HEAD       = 0;
  localparam int HOLD_PLAT       = 1;
  localparam int HOLD_PEXT       = 2;
  localparam int HOLD_TOP        = 3;
  localparam int HOLD_TOM        = 4;
  localparam logic [4:0] HOLD_RST = 5'h00;
  // Platter count straps
  localparam int MAX_DISKS       = 4;
  localparam logic [1:0] FP_RST  = 2'h0;
  localparam logic       LATCH_RST = 1'b0;
endpackage : ddic_pkg

// *** logic/ddic_sync_if.sv ***
`timescale 1ns/1ps
interface ddic_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : ddic_sync_if

// *** logic/ddic_sync.sv ***
`timescale 1ns/1ps
module ddic_sync
  import ddic_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic clk,
  input  wire logic rst,
  ddic_sync_if.sync s
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] cl_q;
  logic [W-1:0] agree;

  // Only stages two and three are compared; stage one is metastable-prone
  assign agree   = ~(s2_q ^ s3_q);
  assign s.clean = cl_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      cl_q <= '0;
    end else begin
      s1_q <= s.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      cl_q <= (s2_q & agree) | (cl_q & ~agree);
    end
  end
endmodule : ddic_sync

// *** logic/ddic_ctrl.sv ***
`timescale 1ns/1ps
// Function
// - Hold select and offset lines, loading gated by ready states.
// - Forward five held values to read/write; offsets also to servo.
// - Re-drive serial write data as double-frequency write signal.
// - Select only when cable unit number equals panel switch number.
// - Busy-seeking output is positioner busy and ready, keyed by unit switch.
// - Interface ready output equals selected-and-ready.
// - Recovered read data and clock go to interface outputs.
// - Attention on becoming ready, seek done, seek fail, illegal address.
// - Double-track status asserted on high track-density model.
// - Illegal-address condition driven to illegal cylinder status output.
// - Dual-platter status for two disks, quad-platter for four.
// - Write and erase need selected-ready, position mode, unprotected disk.
// - Produce no-write-or-erase indication for start/stop sequencer.
// - Read enable gated by selected-and-ready.
// - File-protect latch set or cleared from platter lines and switch.
// - Protected disk has write and erase inhibited.
// - File protected status is latch qualified by selected-and-ready.
// - Protect lamps follow switches regardless of addressed disk; dual units keep the upper two lamps dark.
// - Interrupt option presents attention lines unqualified by unit select.
// - Start/stop blocks retraction while write or erase in progress.
module ddic_ctrl
  import ddic_pkg::*;
#(
  parameter int  NDISK      = 4,
  parameter bit  DOUBLE_TPI = 1'b1,
  parameter bit  INT_OPTION = 1'b0
) (
  input  wire logic              CLOCK,
  input  wire logic              RST,
  input  wire logic              HEAD_SELECT_IN,
  input  wire logic              PLATTER_SELECT_IN,
  input  wire logic              PLATTER_SELECT_EXT_IN,
  input  wire logic              PLATTER_SELECT_EXT_ALT_IN,
  input  wire logic              TRACK_OFFSET_PLUS_IN,
  input  wire logic              TRACK_OFFSET_MINUS_IN,
  input  wire logic              WRITE_SERIAL_DATA_IN,
  input  wire logic              WRITE_GATE_IN,
  input  wire logic              ERASE_GATE_IN,
  input  wire logic              READ_GATE_IN,
  input  wire logic [UNIT_W-1:0] UNIT_SELECT_IN,
  input  wire logic [UNIT_W-1:0] UNIT_SWITCH_IN,
  input  wire logic [3:0]        PROTECT_SWITCH_IN,
  input  wire logic              DRIVE_READY_INTERNAL,
  input  wire logic              POSITION_MODE_IN,
  input  wire logic              POSITIONER_BUSY_IN,
  input  wire logic              SEEK_DONE_IN,
  input  wire logic              SEEK_FAIL_IN,
  input  wire logic              ILLEGAL_ADDR_IN,
  input  wire logic              READ_DATA_RW_IN,
  input  wire logic              READ_CLOCK_RW_IN,
  output logic                   RW_HEAD_SELECT,
  output logic                   RW_PLATTER_SELECT,
  output logic                   RW_PLATTER_SELECT_EXT,
  output logic                   RW_TRACK_OFFSET_PLUS,
  output logic                   RW_TRACK_OFFSET_MINUS,
  output logic                   SERVO_TRACK_OFFSET_PLUS,
  output logic                   SERVO_TRACK_OFFSET_MINUS,
  output logic                   RW_WRITE_DF,
  output logic                   RW_WRITE_ENABLE,
  output logic                   RW_ERASE_ENABLE,
  output logic                   RW_READ_ENABLE,
  output logic                   NO_WRITE_OR_ERASE,
  output logic                   SELECTED_AND_READY,
  output logic                   READY_OUT,
  output logic [(1<<UNIT_W)-1:0] BUSY_SEEKING_OUT,
  output logic                   READ_DATA_OUT,
  output logic                   READ_CLOCK_OUT,
  output logic                   ATTN_READY_OUT,
  output logic                   ATTN_SEEK_DONE_OUT,
  output logic                   ATTN_SEEK_FAIL_OUT,
  output logic                   ATTN_ILLEGAL_OUT,
  output logic                   DOUBLE_TRACK_OUT,
  output logic                   ILLEGAL_CYL_OUT,
  output logic                   DUAL_PLATTER_OUT,
  output logic                   QUAD_PLATTER_OUT,
  output logic                   FILE_PROTECTED_OUT,
  output logic [3:0]             PROTECT_LAMP_OUT
);
  localparam int NU = 1 << UNIT_W;
  // Every cable and panel input crosses domains; one vector keeps it compact
  localparam int NIN = 22 + 2 * UNIT_W;

  ddic_sync_if #(.W(NIN)) sif ();

  ddic_sync #(.W(NIN)) u_sync (
    .clk (CLOCK),
    .rst (RST),
    .s   (sif.sync)
  );

  assign sif.raw = {READ_CLOCK_RW_IN, READ_DATA_RW_IN, ILLEGAL_ADDR_IN,
                    SEEK_FAIL_IN, SEEK_DONE_IN, POSITIONER_BUSY_IN,
                    POSITION_MODE_IN, DRIVE_READY_INTERNAL,
                    PROTECT_SWITCH_IN, UNIT_SWITCH_IN, UNIT_SELECT_IN,
                    READ_GATE_IN, ERASE_GATE_IN, WRITE_GATE_IN,
                    WRITE_SERIAL_DATA_IN, TRACK_OFFSET_MINUS_IN,
                    TRACK_OFFSET_PLUS_IN, PLATTER_SELECT_EXT_ALT_IN,
                    PLATTER_SELECT_EXT_IN, PLATTER_SELECT_IN,
                    HEAD_SELECT_IN};

  logic              head_s;
  logic              plat_s;
  logic              pext_s;
  logic              palt_s;
  logic              top_s;
  logic              tom_s;
  logic              wdat_s;
  logic              wgate_s;
  logic              egate_s;
  logic              rgate_s;
  logic [UNIT_W-1:0] usel_s;
  logic [UNIT_W-1:0] usw_s;
  logic [3:0]        psw_s;
  logic              rdy_s;
  logic              pmode_s;
  logic              busy_s;
  logic              sdone_s;
  logic              sfail_s;
  logic              illeg_s;
  logic              rdat_s;
  logic              rclk_s;

  assign {rclk_s, rdat_s, illeg_s, sfail_s, sdone_s, busy_s, pmode_s,
          rdy_s, psw_s, usw_s, usel_s, rgate_s, egate_s, wgate_s, wdat_s,
          tom_s, top_s, palt_s, pext_s, plat_s, head_s}
    = sif.clean;

  function automatic logic [NU-1:0] onehot(input logic [UNIT_W-1:0] n);
    logic [NU-1:0] v;
    v = '0;
    v[n] = 1'b1;
    return v;
  endfunction : onehot

  function automatic logic [1:0] disk_of(input logic p, input logic e);
    return {e, p};
  endfunction : disk_of

  logic            selected;
  logic            sar;
  logic [HOLD_W-1:0] hold_q;
  logic [HOLD_W-1:0] hold_d;
  logic [HOLD_W-1:0] hold_in;
  logic [1:0]      disk_idx;
  logic            fp_q;
  logic            fp_d;
  logic            we_ok;
  logic            rdy_prev_q;
  logic            busy_prev_q;
  logic            attn_qual;
  logic [NU-1:0]   busy_enc;
  logic [3:0]      lamp_d;

  assign selected = (usel_s == usw_s);
  assign sar      = selected & rdy_s;

  assign hold_in = {tom_s, top_s, pext_s, plat_s, head_s};
  // Retains while unselected or not ready so outputs stay steady mid-seek
  assign hold_d  = sar ? hold_in : hold_q;

  // Quad units decode extension; dual units have disks 0 and 1 only
  assign disk_idx = (NDISK == MAX_DISKS) ? disk_of(plat_s, pext_s | palt_s)
                                         : disk_of(plat_s, 1'b0);
  assign fp_d   = psw_s[disk_idx];
  assign we_ok  = sar & pmode_s & ~fp_q;

  // Only positioner busy while ready counts; encoded on this unit's line
  assign busy_enc = (busy_s & rdy_s) ? onehot(usw_s) : '0;

  // With the interrupt option, attention is shown without unit select
  assign attn_qual = INT_OPTION ? 1'b1 : selected;

  // Quad units light all four lamps; dual units leave the upper pair dark
  for (genvar i = 0; i < 4; i++) begin : g_lamp
    assign lamp_d[i] = (i < NDISK) ? psw_s[i] : 1'b0;
  end

  // Next values of the registered outputs, except ready, busy and lamp lines, which load sar, busy_enc and lamp_d
  logic [HOLD_W-1:0] rw_sel_d;
  logic [1:0]        servo_d;
  logic              wdf_d;
  logic              wen_d;
  logic              een_d;
  logic              ren_d;
  logic              nwoe_d;
  logic              rdat_d;
  logic              rclk_d;
  logic              rdy_rise;
  logic              busy_fall;
  logic              attn_rdy_d;
  logic              attn_done_d;
  logic              attn_fail_d;
  logic              attn_ill_d;
  logic              dtrk_d;
  logic              illcyl_d;
  logic              dual_d;
  logic              quad_d;
  logic              fprot_d;

  assign rw_sel_d    = hold_q;
  assign servo_d     = {hold_q[HOLD_TOM], hold_q[HOLD_TOP]};
  // Fixed latency through the synchroniser keeps bit timing intact
  assign wdf_d       = wdat_s;
  assign wen_d       = wgate_s & we_ok;
  assign een_d       = egate_s & we_ok;
  assign ren_d       = rgate_s & sar;
  // Raw gates, so retraction is blocked even if gating drops them
  assign nwoe_d      = ~(wgate_s | egate_s);
  assign rdat_d      = rdat_s;
  assign rclk_d      = rclk_s;

  // Edges are taken after the filter, so a short glitch makes none
  assign rdy_rise    = rdy_s & ~rdy_prev_q;
  assign busy_fall   = busy_prev_q & ~busy_s;
  assign attn_rdy_d  = attn_qual & rdy_rise;
  assign attn_done_d = attn_qual & rdy_s & (busy_fall | sdone_s);
  assign attn_fail_d = attn_qual & sfail_s;
  assign attn_ill_d  = attn_qual & illeg_s;

  assign dtrk_d      = DOUBLE_TPI;
  assign illcyl_d    = illeg_s;
  assign dual_d      = (NDISK == 2);
  assign quad_d      = (NDISK == MAX_DISKS);
  assign fprot_d     = fp_q & sar;

  // Holding register for the surface select and offset lines
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      hold_q <= HOLD_RST;
    end else begin
      hold_q <= hold_d;
    end
  end

  // Protect latch follows the addressed disk's switch one clock late
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      fp_q <= LATCH_RST;
    end else begin
      fp_q <= fp_d;
    end
  end

  // Previous levels for the attention edge detectors; both idle low
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdy_prev_q  <= 1'b0;
      busy_prev_q <= 1'b0;
    end else begin
      rdy_prev_q  <= rdy_s;
      busy_prev_q <= busy_s;
    end
  end

  // Select and offset lines toward the read/write and servo electronics
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RW_HEAD_SELECT           <= 1'b0;
      RW_PLATTER_SELECT        <= 1'b0;
      RW_PLATTER_SELECT_EXT    <= 1'b0;
      RW_TRACK_OFFSET_PLUS     <= 1'b0;
      RW_TRACK_OFFSET_MINUS    <= 1'b0;
      SERVO_TRACK_OFFSET_PLUS  <= 1'b0;
      SERVO_TRACK_OFFSET_MINUS <= 1'b0;
    end else begin
      RW_HEAD_SELECT           <= rw_sel_d[HOLD_HEAD];
      RW_PLATTER_SELECT        <= rw_sel_d[HOLD_PLAT];
      RW_PLATTER_SELECT_EXT    <= rw_sel_d[HOLD_PEXT];
      RW_TRACK_OFFSET_PLUS     <= rw_sel_d[HOLD_TOP];
      RW_TRACK_OFFSET_MINUS    <= rw_sel_d[HOLD_TOM];
      SERVO_TRACK_OFFSET_PLUS  <= servo_d[0];
      SERVO_TRACK_OFFSET_MINUS <= servo_d[1];
    end
  end

  // Write, erase and read gating toward the read/write electronics
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RW_WRITE_DF       <= 1'b0;
      RW_WRITE_ENABLE   <= 1'b0;
      RW_ERASE_ENABLE   <= 1'b0;
      RW_READ_ENABLE    <= 1'b0;
      NO_WRITE_OR_ERASE <= 1'b1;
    end else begin
      RW_WRITE_DF       <= wdf_d;
      RW_WRITE_ENABLE   <= wen_d;
      RW_ERASE_ENABLE   <= een_d;
      RW_READ_ENABLE    <= ren_d;
      NO_WRITE_OR_ERASE <= nwoe_d;
    end
  end

  // Ready, busy and read signal drivers toward the controller
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      SELECTED_AND_READY <= 1'b0;
      READY_OUT          <= 1'b0;
      BUSY_SEEKING_OUT   <= '0;
      READ_DATA_OUT      <= 1'b0;
      READ_CLOCK_OUT     <= 1'b0;
    end else begin
      SELECTED_AND_READY <= sar;
      READY_OUT          <= sar;
      BUSY_SEEKING_OUT   <= busy_enc;
      READ_DATA_OUT      <= rdat_d;
      READ_CLOCK_OUT     <= rclk_d;
    end
  end

  // Attention lines; the ready one is a single-clock pulse
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ATTN_READY_OUT     <= 1'b0;
      ATTN_SEEK_DONE_OUT <= 1'b0;
      ATTN_SEEK_FAIL_OUT <= 1'b0;
      ATTN_ILLEGAL_OUT   <= 1'b0;
    end else begin
      ATTN_READY_OUT     <= attn_rdy_d;
      ATTN_SEEK_DONE_OUT <= attn_done_d;
      ATTN_SEEK_FAIL_OUT <= attn_fail_d;
      ATTN_ILLEGAL_OUT   <= attn_ill_d;
    end
  end

  // Configuration, illegal address and protect status
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      DOUBLE_TRACK_OUT   <= 1'b0;
      ILLEGAL_CYL_OUT    <= 1'b0;
      DUAL_PLATTER_OUT   <= 1'b0;
      QUAD_PLATTER_OUT   <= 1'b0;
      FILE_PROTECTED_OUT <= 1'b0;
      PROTECT_LAMP_OUT   <= 4'h0;
    end else begin
      DOUBLE_TRACK_OUT   <= dtrk_d;
      ILLEGAL_CYL_OUT    <= illcyl_d;
      DUAL_PLATTER_OUT   <= dual_d;
      QUAD_PLATTER_OUT   <= quad_d;
      FILE_PROTECTED_OUT <= fprot_d;
      PROTECT_LAMP_OUT   <= lamp_d;
    end
  end
endmodule : ddic_ctrl

// *** dv/ddic_ctrl_checker.sv ***
`timescale 1ns/1ps
module ddic_ctrl_checker
  import ddic_pkg::*;
#(
  parameter int NDISK      = 4,
  parameter bit DOUBLE_TPI = 1'b1
) (
  input wire logic              CLOCK,
  input wire logic              RST,
  input wire logic              WRITE_GATE_IN,
  input wire logic              ERASE_GATE_IN,
  input wire logic              POSITION_MODE_IN,
  input wire logic              DRIVE_READY_INTERNAL,
  input wire logic              POSITIONER_BUSY_IN,
  input wire logic [UNIT_W-1:0] UNIT_SELECT_IN,
  input wire logic [UNIT_W-1:0] UNIT_SWITCH_IN,
  input wire logic [3:0]        PROTECT_SWITCH_IN,
  input wire logic              RW_WRITE_ENABLE,
  input wire logic              RW_ERASE_ENABLE,
  input wire logic              RW_READ_ENABLE,
  input wire logic              NO_WRITE_OR_ERASE,
  input wire logic              SELECTED_AND_READY,
  input wire logic              READY_OUT,
  input wire logic [3:0]        BUSY_SEEKING_OUT,
  input wire logic [3:0]        PROTECT_LAMP_OUT,
  input wire logic              DOUBLE_TRACK_OUT,
  input wire logic              QUAD_PLATTER_OUT,
  input wire logic              DUAL_PLATTER_OUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Eight quiet cycles cover the input filter plus the output register
  sequence s_not_ready; (!DRIVE_READY_INTERNAL)[*8]; endsequence
  sequence s_gates_off; (!WRITE_GATE_IN && !ERASE_GATE_IN)[*8]; endsequence
  sequence s_no_pos; (!POSITION_MODE_IN)[*8]; endsequence
  property p_ready; READY_OUT == SELECTED_AND_READY; endproperty
  property p_unit; (UNIT_SELECT_IN != UNIT_SWITCH_IN)[*8] |->
    !SELECTED_AND_READY; endproperty
  property p_read; s_not_ready |-> !RW_READ_ENABLE && !READY_OUT; endproperty
  property p_pos; s_no_pos |-> !RW_WRITE_ENABLE && !RW_ERASE_ENABLE;
  endproperty
  property p_prot; (PROTECT_SWITCH_IN == 4'hF)[*8] |->
    !RW_WRITE_ENABLE && !RW_ERASE_ENABLE; endproperty
  property p_nwoe; s_gates_off |-> NO_WRITE_OR_ERASE; endproperty
  property p_busy; (!POSITIONER_BUSY_IN)[*8] |-> BUSY_SEEKING_OUT == 4'h0;
  endproperty
  property p_lamp; $stable(PROTECT_SWITCH_IN)[*8] |->
    PROTECT_LAMP_OUT == PROTECT_SWITCH_IN; endproperty
  property p_cfg; (!RST)[*2] |-> DOUBLE_TRACK_OUT == DOUBLE_TPI &&
    QUAD_PLATTER_OUT == (NDISK == 4) && DUAL_PLATTER_OUT == (NDISK == 2);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready line differs from selected and ready");
  a_unit: assert property (p_unit)
    else $error("selected while unit number differs");
  a_read: assert property (p_read)
    else $error("read enable or ready while not ready");
  a_pos: assert property (p_pos)
    else $error("write or erase without position mode");
  a_prot: assert property (p_prot)
    else $error("write or erase on protected disk");
  a_nwoe: assert property (p_nwoe)
    else $error("no write or erase flag low while gates idle");
  a_busy: assert property (p_busy)
    else $error("busy seeking without positioner busy");
  a_lamp: assert property (p_lamp)
    else $error("protect lamps differ from switches");
  a_cfg: assert property (p_cfg)
    else $error("configuration status lines wrong");
endmodule : ddic_ctrl_checker

bind ddic_ctrl ddic_ctrl_checker #(.NDISK(NDISK), .DOUBLE_TPI(DOUBLE_TPI))
  ddic_ctrl_checker_i (.*);

// *** dv/ddic_host_model.sv ***
`timescale 1ns/1ps
module ddic_host_model (
  input  wire logic en,
  output logic      wdata
);
  // Write data toggles at a 200 ns period only inside a write stream
  initial wdata = 1'b0;
  always begin
    #100;
    wdata <= en ? ~wdata : 1'b0;
  end
endmodule : ddic_host_model

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import ddic_pkg::*;
  logic CLOCK = 1'b0, RST = 1'b1, wr_stream = 1'b0;
  logic HEAD_SELECT_IN, PLATTER_SELECT_IN, PLATTER_SELECT_EXT_IN,
    PLATTER_SELECT_EXT_ALT_IN, TRACK_OFFSET_PLUS_IN, TRACK_OFFSET_MINUS_IN,
    WRITE_SERIAL_DATA_IN, WRITE_GATE_IN, ERASE_GATE_IN, READ_GATE_IN,
    DRIVE_READY_INTERNAL, POSITION_MODE_IN, POSITIONER_BUSY_IN, SEEK_DONE_IN,
    SEEK_FAIL_IN, ILLEGAL_ADDR_IN, READ_DATA_RW_IN, READ_CLOCK_RW_IN;
  logic [UNIT_W-1:0] UNIT_SELECT_IN, UNIT_SWITCH_IN;
  logic [3:0] PROTECT_SWITCH_IN, BUSY_SEEKING_OUT, PROTECT_LAMP_OUT;
  logic RW_HEAD_SELECT, RW_PLATTER_SELECT, RW_PLATTER_SELECT_EXT,
    RW_TRACK_OFFSET_PLUS, RW_TRACK_OFFSET_MINUS, SERVO_TRACK_OFFSET_PLUS,
    SERVO_TRACK_OFFSET_MINUS, RW_WRITE_DF, RW_WRITE_ENABLE, RW_ERASE_ENABLE,
    RW_READ_ENABLE, NO_WRITE_OR_ERASE, SELECTED_AND_READY, READY_OUT,
    READ_DATA_OUT, READ_CLOCK_OUT, ATTN_READY_OUT, ATTN_SEEK_DONE_OUT,
    ATTN_SEEK_FAIL_OUT, ATTN_ILLEGAL_OUT, DOUBLE_TRACK_OUT, ILLEGAL_CYL_OUT,
    DUAL_PLATTER_OUT, QUAD_PLATTER_OUT, FILE_PROTECTED_OUT;
  int mismatches = 0, checks = 0, cyc = 0;
  wire [4:0] held = {RW_TRACK_OFFSET_MINUS, RW_TRACK_OFFSET_PLUS,
    RW_PLATTER_SELECT_EXT, RW_PLATTER_SELECT, RW_HEAD_SELECT};
  ddic_ctrl ddic_ctrl_i (.*);
  ddic_host_model ddic_host_model_i (.en(wr_stream),
    .wdata(WRITE_SERIAL_DATA_IN));
  always #12.5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Outputs settle within six edges of an input change
  task automatic settle(); repeat (8) @(negedge CLOCK); endtask : settle
  task automatic t_select();
    {UNIT_SWITCH_IN, UNIT_SELECT_IN, DRIVE_READY_INTERNAL} = 5'h15;
    POSITIONER_BUSY_IN = 1'b1; settle();
    chk(READY_OUT, 1);
    chk(BUSY_SEEKING_OUT, 4'h4);
    UNIT_SELECT_IN = 2'h1; settle();
    chk({SELECTED_AND_READY, READY_OUT}, 0);
    UNIT_SELECT_IN = 2'h2; POSITIONER_BUSY_IN = 1'b0; settle();
    chk(BUSY_SEEKING_OUT, 0);
  endtask : t_select
  task automatic t_hold();
    {TRACK_OFFSET_MINUS_IN, TRACK_OFFSET_PLUS_IN, PLATTER_SELECT_EXT_IN,
      PLATTER_SELECT_IN, HEAD_SELECT_IN} = 5'h15; settle();
    chk(held, 5'h15);
    chk({SERVO_TRACK_OFFSET_MINUS, SERVO_TRACK_OFFSET_PLUS}, 2'h2);
    DRIVE_READY_INTERNAL = 1'b0;
    {TRACK_OFFSET_MINUS_IN, TRACK_OFFSET_PLUS_IN, PLATTER_SELECT_EXT_IN,
      PLATTER_SELECT_IN, HEAD_SELECT_IN} = 5'h0A; settle();
    chk(held, 5'h15);
    DRIVE_READY_INTERNAL = 1'b1; settle();
    chk(held, 5'h0A);
  endtask : t_hold
  task automatic t_write();
    int n;
    logic p;
    {POSITION_MODE_IN, WRITE_GATE_IN, ERASE_GATE_IN} = 3'h7;
    for (int d = 0; d < 4; d++) begin
      for (int s = 0; s < 4; s++) begin
        PROTECT_SWITCH_IN = 4'h1 << d;
        {PLATTER_SELECT_EXT_IN, PLATTER_SELECT_IN} = s[1:0]; settle();
        chk({RW_WRITE_ENABLE, RW_ERASE_ENABLE}, (s == d) ? 0 : 3);
        chk(FILE_PROTECTED_OUT, s == d);
        chk(PROTECT_LAMP_OUT, 4'h1 << d);
      end
    end
    // Disk 3 protected; the alternate extension line must reach it too
    PLATTER_SELECT_EXT_ALT_IN = 1'b1;
    PLATTER_SELECT_EXT_IN = 1'b0;
    settle();
    chk(FILE_PROTECTED_OUT, 5'h01);
    chk({RW_WRITE_ENABLE, RW_ERASE_ENABLE}, 5'h00);
    PLATTER_SELECT_EXT_ALT_IN = 1'b0;
    PROTECT_SWITCH_IN = 4'hF; settle();
    chk(RW_WRITE_ENABLE, 0);
    PROTECT_SWITCH_IN = 4'h0; settle();
    chk(NO_WRITE_OR_ERASE, 0);
    wr_stream = 1'b1; n = 0; p = RW_WRITE_DF;
    repeat (80) begin
      @(negedge CLOCK);
      n += (RW_WRITE_DF !== p);
      p = RW_WRITE_DF;
    end
    wr_stream = 1'b0;
    chk(n >= 19 && n <= 21, 1);
    POSITION_MODE_IN = 1'b0; settle();
    chk({RW_WRITE_ENABLE, RW_ERASE_ENABLE}, 0);
    {POSITION_MODE_IN, WRITE_GATE_IN, ERASE_GATE_IN} = 3'h4; settle();
    chk(NO_WRITE_OR_ERASE, 1);
  endtask : t_write
  task automatic t_read();
    {READ_GATE_IN, READ_DATA_RW_IN, READ_CLOCK_RW_IN} = 3'h6; settle();
    chk({RW_READ_ENABLE, READ_DATA_OUT, READ_CLOCK_OUT}, 3'h6);
    {READ_DATA_RW_IN, READ_CLOCK_RW_IN} = 2'h1; DRIVE_READY_INTERNAL = 0;
    settle();
    chk({RW_READ_ENABLE, READ_DATA_OUT, READ_CLOCK_OUT}, 3'h1);
  endtask : t_read
  task automatic t_status();
    int n;
    n = 0;
    DRIVE_READY_INTERNAL = 1'b1;
    repeat (10) begin
      @(negedge CLOCK);
      n += ATTN_READY_OUT;
    end
    chk(n, 1);
    {ILLEGAL_ADDR_IN, SEEK_FAIL_IN, SEEK_DONE_IN} = 3'h7; settle();
    chk({ILLEGAL_CYL_OUT, ATTN_ILLEGAL_OUT, ATTN_SEEK_FAIL_OUT,
      ATTN_SEEK_DONE_OUT}, 4'hF);
    chk({DOUBLE_TRACK_OUT, QUAD_PLATTER_OUT, DUAL_PLATTER_OUT}, 6);
    {ILLEGAL_ADDR_IN, SEEK_FAIL_IN, SEEK_DONE_IN} = 3'h0; settle();
    chk({ILLEGAL_CYL_OUT, ATTN_ILLEGAL_OUT, ATTN_SEEK_FAIL_OUT}, 0);
    // Without the interrupt option attention needs this unit addressed
    UNIT_SELECT_IN = 2'h1;
    SEEK_FAIL_IN = 1'b1;
    settle();
    chk(ATTN_SEEK_FAIL_OUT, 5'h00);
  endtask : t_status
  initial begin
    {HEAD_SELECT_IN, PLATTER_SELECT_IN, PLATTER_SELECT_EXT_IN,
      PLATTER_SELECT_EXT_ALT_IN, TRACK_OFFSET_PLUS_IN, TRACK_OFFSET_MINUS_IN,
      WRITE_GATE_IN, ERASE_GATE_IN, READ_GATE_IN, DRIVE_READY_INTERNAL,
      POSITION_MODE_IN, POSITIONER_BUSY_IN, SEEK_DONE_IN, SEEK_FAIL_IN,
      ILLEGAL_ADDR_IN, READ_DATA_RW_IN, READ_CLOCK_RW_IN} = '0;
    {UNIT_SELECT_IN, UNIT_SWITCH_IN, PROTECT_SWITCH_IN} = '0;
    repeat (3) @(negedge CLOCK);
    RST = 1'b0;
    t_select();
    t_hold();
    t_write();
    t_read();
    t_status();
    final_report();
  end
endmodule : testbench
